// [src/csp_consts.svh]
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH
// ********************************
// register offsets
// ********************************
`define CSP_OFF_MAINSEL 12'h000
`define CSP_OFF_REFSEL 12'h004
`define CSP_OFF_PLL0 12'h008
`define CSP_OFF_PLL1 12'h00c
`define CSP_OFF_PLL2 12'h010
`define CSP_OFF_STATUS 12'h014
`define CSP_OFF_CLKOUTSEL 12'h018
`define CSP_OFF_PERCLK 12'h01c
`define CSP_OFF_SLEEP 12'h020
// ********************************
// field positions
// ********************************
`define CSP_PLL_MSEL_LSB 0
`define CSP_PLL_PSEL_LSB 5
`define CSP_PLL_EN_BIT 7
`define CSP_STAT_LOCK_LSB 0
`define CSP_STAT_MAIN_LSB 4
// ********************************
// source codes
// ********************************
`define CSP_SRC_RCOSC 3'h0
`define CSP_SRC_SYSOSC 3'h1
`define CSP_SRC_WDOSC 3'h2
`define CSP_SRC_RTC32K 3'h3
`define CSP_SRC_SYSPLL 3'h4
`define CSP_SRC_MAIN 3'h7
`define CSP_MAIN_SEL_MAX 3'h4
// ********************************
// reset values
// ********************************
`define CSP_RST_MAINSEL `CSP_SRC_RCOSC
`define CSP_RST_CLKOUTSEL `CSP_SRC_RCOSC
`define CSP_RST_REFSEL 3'h0
`define CSP_RST_PERCLK 1'b1
// ********************************
// timing
// ********************************
`define CSP_CLK_MHZ 25
`define CSP_PLL_SETTLE_US 100
`define CSP_PLL_LOCK_CYC (`CSP_PLL_SETTLE_US * `CSP_CLK_MHZ)
`define CSP_RTC_KHZ_DIV 32
`define CSP_RTC_HZ_DIV 1024
`endif

// [src/csp_pkg.sv]
package csp_pkg;
    typedef struct packed {
        logic en;
        logic [1:0] psel;
        logic [4:0] msel;
    } csp_pll_cfg_t;

    typedef enum logic {SW_RUN, SW_PARK} csp_sw_state_t;
endpackage

// [src/csp_pll.sv]
`timescale 1ns/1ns
`default_nettype none
`include "csp_consts.svh"
module csp_pll
    import csp_pkg::*;
#(
    parameter int LOCK_CYC = `CSP_PLL_LOCK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ref_lvl,
    input wire logic ctl_osc_lvl,
    input wire csp_pll_cfg_t cfg,
    output logic pll_out,
    output logic locked,
    output logic pd,
    output logic [5:0] mult,
    output logic [1:0] pdiv_sel
);
    // ********************************
    // config tracking
    // ********************************
    csp_pll_cfg_t cfg_reg;
    logic ctl_osc_reg;
    logic [3:0] div_cnt_reg;
    logic [11:0] lock_cnt_reg;
    logic [11:0] age_reg;
    logic cfg_chg;
    logic [3:0] half;

    assign cfg_chg = (cfg != cfg_reg);
    assign half = 4'h1 << cfg.psel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= '0;
            ctl_osc_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg;
            ctl_osc_reg <= ctl_osc_lvl;
        end
    end

    // ********************************
    // analog core controls
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd <= 1'b1;
            mult <= 6'h01;
            pdiv_sel <= 2'h0;
        end else begin
            pd <= !cfg.en;
            mult <= 6'(cfg.msel) + 6'h01;
            pdiv_sel <= cfg.psel;
        end
    end

    // ********************************
    // lock timer
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_reg <= '0;
            locked <= 1'b0;
        end else if (!cfg.en || cfg_chg) begin
            lock_cnt_reg <= '0;
            locked <= 1'b0;
        end else if (!locked) begin
            if (lock_cnt_reg == 12'(LOCK_CYC - 1)) begin
                locked <= 1'b1;
            end
            lock_cnt_reg <= lock_cnt_reg + 12'h001;
        end
    end

    // ********************************
    // post divider and bypass
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_out <= 1'b0;
            div_cnt_reg <= '0;
        end else if (!cfg.en) begin
            pll_out <= ref_lvl;
            div_cnt_reg <= '0;
        end else if (ctl_osc_lvl && !ctl_osc_reg) begin
            if (div_cnt_reg >= half - 4'h1) begin
                div_cnt_reg <= '0;
                pll_out <= !pll_out;
            end else begin
                div_cnt_reg <= div_cnt_reg + 4'h1;
            end
        end
    end

    // ********************************
    // checks
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_reg <= '0;
        end else if (!cfg.en || cfg_chg) begin
            age_reg <= '0;
        end else if (age_reg != 12'hfff) begin
            age_reg <= age_reg + 12'h001;
        end
    end

    a_lock_wait: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(locked) |-> (age_reg == 12'(LOCK_CYC)))
        else $error("pll lock not at settle time");
    a_lock_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (!cfg.en || cfg_chg) |=> !locked)
        else $error("pll lock kept after disable or change");
    a_bypass_off: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.en |=> (pd && pll_out == $past(ref_lvl)))
        else $error("disabled pll not bypassed");
endmodule
`default_nettype wire

// [src/csp_clk_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
`include "csp_consts.svh"
// How it works
// - reset always selects internal RC, wake keeps the selected source
// - three identical PLLs: system, USB, timer
// - internal RC usable as every PLL reference
// - multiplier accepts every integer 1 to 32
// - post divider ratios only 2,4,8,16
// - output toggles, so duty is 50 percent
// - PLLs off and bypassed after reset
// - lock reported 100 us after valid enable
// - watchdog oscillator drives core, watchdog, pin
// - RTC oscillator gives 1 Hz, 1 kHz, 32k
// - clock output pin routes any chosen clock
// - per-peripheral clock enable bits
// - sleep stops core clock, wake re-enables it
// - sleep ends on reset or interrupt
module csp_clk_ctrl
    import csp_pkg::*;
#(
    parameter int NPER = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic internal_rc_osc,
    input wire logic sysosc_clk,
    input wire logic wdosc_clk,
    input wire logic rtc32k_clk,
    input wire logic [2:0] current_controlled_osc,
    input wire logic irq_pending,
    output logic main_clk,
    output logic core_clk,
    output logic clock_output_pin,
    output logic wdt_clk,
    output logic [NPER-1:0] periph_clk,
    output logic rtc_1hz_tick,
    output logic rtc_1khz_tick,
    output logic [2:0] pll_pd,
    output logic [2:0][5:0] pll_mult,
    output logic [2:0][1:0] pll_pdiv
);
    // ********************************
    // source synchronisers
    // ********************************
    logic [6:0] src_ff1;
    logic [6:0] src_lvl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_ff1 <= '0;
            src_lvl <= '0;
        end else begin
            src_ff1 <= {current_controlled_osc, rtc32k_clk, wdosc_clk, sysosc_clk,
                internal_rc_osc};
            src_lvl <= src_ff1;
        end
    end

    // ********************************
    // registers
    // ********************************
    logic [2:0] mainsel_reg;
    logic [2:0] refsel_reg;
    logic [2:0] clkoutsel_reg;
    logic [NPER-1:0] perclk_reg;
    logic sleep_reg;
    csp_pll_cfg_t pll_cfg_reg [3];
    logic [2:0] sw_cur [2];
    logic [2:0] pll_lock;
    logic [2:0] pll_lvl;
    logic wr_en;
    logic rd_setup;
    logic [31:0] rd_next;
    logic err_next;

    assign wr_en = psel && penable && pready && pwrite;
    assign rd_setup = psel && !penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mainsel_reg <= `CSP_RST_MAINSEL;
            refsel_reg <= `CSP_RST_REFSEL;
            clkoutsel_reg <= `CSP_RST_CLKOUTSEL;
            perclk_reg <= {NPER{`CSP_RST_PERCLK}};
        end else if (wr_en) begin
            if (paddr == `CSP_OFF_MAINSEL) begin
                if (pwdata[2:0] <= `CSP_MAIN_SEL_MAX) begin
                    mainsel_reg <= pwdata[2:0];
                end
            end else if (paddr == `CSP_OFF_REFSEL) begin
                refsel_reg <= pwdata[2:0];
            end else if (paddr == `CSP_OFF_CLKOUTSEL) begin
                clkoutsel_reg <= pwdata[2:0];
            end else if (paddr == `CSP_OFF_PERCLK) begin
                perclk_reg <= pwdata[NPER-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                pll_cfg_reg[i] <= '0;
            end
        end else if (wr_en) begin
            if (paddr == `CSP_OFF_PLL0) begin
                pll_cfg_reg[0] <= pwdata[7:0];
            end else if (paddr == `CSP_OFF_PLL1) begin
                pll_cfg_reg[1] <= pwdata[7:0];
            end else if (paddr == `CSP_OFF_PLL2) begin
                pll_cfg_reg[2] <= pwdata[7:0];
            end
        end
    end

    // ********************************
    // sleep control
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_reg <= 1'b0;
        end else if (irq_pending) begin
            sleep_reg <= 1'b0;
        end else if (wr_en && paddr == `CSP_OFF_SLEEP && pwdata[0]) begin
            sleep_reg <= 1'b1;
        end
    end

    // ********************************
    // apb slave
    // ********************************
    always_comb begin
        rd_next = '0;
        err_next = 1'b0;
        if (paddr == `CSP_OFF_MAINSEL) begin
            rd_next[2:0] = mainsel_reg;
        end else if (paddr == `CSP_OFF_REFSEL) begin
            rd_next[2:0] = refsel_reg;
        end else if (paddr == `CSP_OFF_PLL0) begin
            rd_next[7:0] = pll_cfg_reg[0];
        end else if (paddr == `CSP_OFF_PLL1) begin
            rd_next[7:0] = pll_cfg_reg[1];
        end else if (paddr == `CSP_OFF_PLL2) begin
            rd_next[7:0] = pll_cfg_reg[2];
        end else if (paddr == `CSP_OFF_STATUS) begin
            rd_next[`CSP_STAT_LOCK_LSB +: 3] = pll_lock;
            rd_next[`CSP_STAT_MAIN_LSB +: 3] = sw_cur[0];
        end else if (paddr == `CSP_OFF_CLKOUTSEL) begin
            rd_next[2:0] = clkoutsel_reg;
        end else if (paddr == `CSP_OFF_PERCLK) begin
            rd_next[NPER-1:0] = perclk_reg;
        end else if (paddr == `CSP_OFF_SLEEP) begin
            rd_next[0] = sleep_reg;
        end else begin
            err_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_setup;
            pslverr <= rd_setup && err_next;
            if (rd_setup && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end

    // ********************************
    // plls
    // ********************************
    for (genvar g = 0; g < 3; g++) begin : g_pll
        csp_pll u_pll (
            .pclk(pclk),
            .presetn(presetn),
            .ref_lvl(refsel_reg[g] ? src_lvl[1] : src_lvl[0]),
            .ctl_osc_lvl(src_lvl[4+g]),
            .cfg(pll_cfg_reg[g]),
            .pll_out(pll_lvl[g]),
            .locked(pll_lock[g]),
            .pd(pll_pd[g]),
            .mult(pll_mult[g]),
            .pdiv_sel(pll_pdiv[g])
        );
    end

    // ********************************
    // glitch-free switches
    // ********************************
    function automatic logic pick(input logic [2:0] sel, input logic [7:0] lv);
        return lv[sel];
    endfunction

    logic [7:0] all_lvl;
    logic [2:0] sw_req [2];
    logic sw_out [2];
    csp_sw_state_t sw_st [2];

    assign all_lvl = {main_clk, pll_lvl, src_lvl[3:0]};
    assign sw_req[0] = mainsel_reg;
    assign sw_req[1] = clkoutsel_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 2; i++) begin
                sw_cur[i] <= `CSP_SRC_RCOSC;
                sw_out[i] <= 1'b0;
                sw_st[i] <= SW_RUN;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                case (sw_st[i])
                    SW_RUN: begin
                        sw_out[i] <= pick(sw_cur[i], all_lvl);
                        if (sw_req[i] != sw_cur[i] && !pick(sw_cur[i], all_lvl)) begin
                            sw_out[i] <= 1'b0;
                            sw_st[i] <= SW_PARK;
                        end
                    end
                    SW_PARK: begin
                        sw_out[i] <= 1'b0;
                        if (!pick(sw_req[i], all_lvl)) begin
                            sw_cur[i] <= sw_req[i];
                            sw_st[i] <= SW_RUN;
                        end
                    end
                    default: sw_st[i] <= SW_RUN;
                endcase
            end
        end
    end

    assign main_clk = sw_out[0];
    assign clock_output_pin = sw_out[1];

    // ********************************
    // clock gates
    // ********************************
    logic core_en_reg;
    logic [NPER-1:0] per_en_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_en_reg <= 1'b1;
            per_en_reg <= {NPER{`CSP_RST_PERCLK}};
            core_clk <= 1'b0;
            periph_clk <= '0;
            wdt_clk <= 1'b0;
        end else begin
            if (!main_clk) begin
                core_en_reg <= !sleep_reg;
                per_en_reg <= perclk_reg;
            end
            core_clk <= main_clk && core_en_reg;
            periph_clk <= {NPER{main_clk}} & per_en_reg;
            wdt_clk <= src_lvl[2];
        end
    end

    // ********************************
    // rtc ticks
    // ********************************
    logic rtc_prev_reg;
    logic [4:0] khz_cnt_reg;
    logic [9:0] hz_cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_prev_reg <= 1'b0;
            khz_cnt_reg <= '0;
            hz_cnt_reg <= '0;
            rtc_1khz_tick <= 1'b0;
            rtc_1hz_tick <= 1'b0;
        end else begin
            rtc_prev_reg <= src_lvl[3];
            rtc_1khz_tick <= 1'b0;
            rtc_1hz_tick <= 1'b0;
            if (src_lvl[3] && !rtc_prev_reg) begin
                khz_cnt_reg <= khz_cnt_reg + 5'h01;
                if (khz_cnt_reg == 5'(`CSP_RTC_KHZ_DIV - 1)) begin
                    rtc_1khz_tick <= 1'b1;
                    hz_cnt_reg <= hz_cnt_reg + 10'h001;
                    rtc_1hz_tick <= (hz_cnt_reg == 10'(`CSP_RTC_HZ_DIV - 1));
                end
            end
        end
    end

    // ********************************
    // checks
    // ********************************
    sequence s_sleep_req;
        wr_en && paddr == `CSP_OFF_SLEEP && pwdata[0] && !irq_pending;
    endsequence

    a_rc_default: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(mainsel_reg) |-> $past(wr_en && paddr == `CSP_OFF_MAINSEL))
        else $error("main select moved without a write");
    a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
        s_sleep_req ##1 (sleep_reg && !main_clk) |=> ##1 !core_clk)
        else $error("core clock not stopped in sleep");
    a_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_reg && irq_pending) |=> !sleep_reg)
        else $error("interrupt did not end sleep");
    a_glitch_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (sw_st[0] == SW_PARK) |=> !main_clk)
        else $error("main clock high while parked");
    a_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
        (!per_en_reg[0]) |=> !periph_clk[0])
        else $error("gated peripheral clock running");
endmodule
`default_nettype wire

// [sim/csp_osc_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// oscillators and pll current-controlled oscillators
// ****************************************
module csp_osc_model #(
    parameter int RC_HALF = 200,
    parameter int SYS_HALF = 280,
    parameter int WD_HALF = 500,
    parameter int RTC_HALF = 600,
    parameter int CTL_OSC_HALF = 100
) (
    input wire logic [2:0] pll_pd,
    output logic internal_rc_osc,
    output logic sysosc_clk,
    output logic wdosc_clk,
    output logic rtc32k_clk,
    output logic [2:0] current_controlled_osc
);
    logic ctl_osc_ph = 1'b0;

    initial begin
        internal_rc_osc = 1'b0;
        sysosc_clk = 1'b0;
        wdosc_clk = 1'b0;
        rtc32k_clk = 1'b0;
    end
    // scaled rates, ratios kept between sources
    always #RC_HALF internal_rc_osc = ~internal_rc_osc;
    always #SYS_HALF sysosc_clk = ~sysosc_clk;
    always #WD_HALF wdosc_clk = ~wdosc_clk;
    always #RTC_HALF rtc32k_clk = ~rtc32k_clk;
    always #CTL_OSC_HALF ctl_osc_ph = ~ctl_osc_ph;
    // powered-down oscillator stands still
    always_comb begin
        current_controlled_osc = {3{ctl_osc_ph}} & ~pll_pd;
    end
endmodule
`default_nettype wire

// [sim/csp_clk_ctrl_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "csp_consts.svh"
module csp_clk_ctrl_tb_top import csp_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic irq_pending = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, main_clk, core_clk, clock_output_pin, wdt_clk;
    logic rtc_1hz_tick, rtc_1khz_tick, rc, sys, wd, rtc, w, err;
    logic [31:0] prdata, rd;
    logic [15:0] periph_clk;
    logic [2:0] pll_pd, ctl_osc;
    logic [2:0][5:0] pll_mult;
    logic [2:0][1:0] pll_pdiv;
    logic [2:0] wsel = 3'h0;
    int n_fail = 0, comparisons = 0, cyc = 0, t, t0;

    always #20 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    csp_clk_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .internal_rc_osc(rc), .sysosc_clk(sys), .wdosc_clk(wd),
        .rtc32k_clk(rtc), .current_controlled_osc(ctl_osc), .irq_pending(irq_pending),
        .main_clk(main_clk), .core_clk(core_clk), .clock_output_pin(clock_output_pin),
        .wdt_clk(wdt_clk), .periph_clk(periph_clk), .rtc_1hz_tick(rtc_1hz_tick),
        .rtc_1khz_tick(rtc_1khz_tick), .pll_pd(pll_pd), .pll_mult(pll_mult),
        .pll_pdiv(pll_pdiv));

    csp_osc_model osc (.pll_pd(pll_pd), .internal_rc_osc(rc), .sysosc_clk(sys),
        .wdosc_clk(wd), .rtc32k_clk(rtc), .current_controlled_osc(ctl_osc));

    // ****************************************
    // helpers
    // ****************************************
    always_comb begin
        case (wsel)
            3'h0: w = clock_output_pin;
            3'h1: w = core_clk;
            3'h2: w = periph_clk[0];
            3'h3: w = periph_clk[1];
            3'h4: w = wdt_clk;
            3'h5: w = main_clk;
            3'h6: w = rtc_1khz_tick;
            default: w = rtc_1hz_tick;
        endcase
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            $display("ERROR pready expected 1 seen %b", pready);
            n_fail++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic toggles(input logic [2:0] s, input int n, output int c);
        logic p;
        wsel = s;
        #1;
        p = w;
        c = 0;
        repeat (n) begin
            @(posedge pclk);
            if (w !== p) c++;
            p = w;
        end
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        $display("ERROR run expected end seen timeout");
        n_fail++;
        final_report();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pll_pd", 32'h7, 32'(pll_pd));
        chk("pll_mult", 32'(18'h01041), 32'(pll_mult));
        rchk("mainsel", `CSP_OFF_MAINSEL, 32'h0);
        rchk("status", `CSP_OFF_STATUS, 32'h0);
        rchk("refsel", `CSP_OFF_REFSEL, 32'h0);
        rchk("perclk", `CSP_OFF_PERCLK, 32'h0000ffff);
        rchk("sleep", `CSP_OFF_SLEEP, 32'h0);
        apb(1'b0, 12'h024, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        $display("test reset done");

        for (int m = 0; m < 32; m++) begin
            apb(1'b1, `CSP_OFF_PLL1, 32'(m) | (32'(m % 4) << 5));
            repeat (3) @(posedge pclk);
            chk("pll_mult", 32'(m + 1), 32'(pll_mult[1]));
            chk("pll_pdiv", 32'(m % 4), 32'(pll_pdiv[1]));
        end
        $display("test multiplier done");

        for (int s = 0; s < 8; s++) begin
            apb(1'b1, `CSP_OFF_CLKOUTSEL, 32'(s));
            toggles(3'h0, 300, t);
            chk("clock output active", 32'h1, 32'(t > 0));
        end
        apb(1'b1, `CSP_OFF_REFSEL, 32'h4);
        rchk("refsel", `CSP_OFF_REFSEL, 32'h4);
        apb(1'b1, `CSP_OFF_CLKOUTSEL, 32'h6);
        repeat (20) @(posedge pclk);
        toggles(3'h0, 140, t);
        chk("pll2 sysosc ref", 32'h1, 32'(t >= 19 && t <= 21));
        apb(1'b1, `CSP_OFF_REFSEL, 32'h0);
        repeat (20) @(posedge pclk);
        toggles(3'h0, 140, t);
        chk("pll2 rc ref", 32'h1, 32'(t >= 27 && t <= 29));
        toggles(3'h4, 200, t);
        chk("wdt active", 32'h1, 32'(t > 0));
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `CSP_OFF_MAINSEL, 32'(s));
            repeat (100) @(posedge pclk);
            rchk("main source", `CSP_OFF_STATUS, 32'(s) << 4);
        end
        apb(1'b1, `CSP_OFF_MAINSEL, 32'h0);
        repeat (100) @(posedge pclk);
        $display("test sources done");

        apb(1'b1, `CSP_OFF_PLL0, 32'h00000087);
        t0 = cyc;
        repeat (3) @(posedge pclk);
        chk("pll0 powered", 32'h6, 32'(pll_pd));
        chk("pll0 mult", 32'h8, 32'(pll_mult[0]));
        while (cyc - t0 < 2300) @(posedge pclk);
        rchk("early lock", `CSP_OFF_STATUS, 32'h0);
        for (int k = 0; k < 200 && rd[0] !== 1'b1; k++) apb(1'b0, `CSP_OFF_STATUS, 32'h0);
        t = cyc - t0;
        chk("lock time", 32'h1, 32'(t >= 2500 && t <= 2512));
        apb(1'b1, `CSP_OFF_MAINSEL, 32'h4);
        repeat (100) @(posedge pclk);
        rchk("pll main", `CSP_OFF_STATUS, 32'h41);
        toggles(3'h5, 200, t);
        chk("pll main active", 32'h1, 32'(t > 0));
        apb(1'b1, `CSP_OFF_MAINSEL, 32'h5);
        rchk("bad select", `CSP_OFF_MAINSEL, 32'h4);
        apb(1'b1, `CSP_OFF_MAINSEL, 32'h0);
        repeat (100) @(posedge pclk);
        apb(1'b1, `CSP_OFF_PLL0, 32'h00000088);
        rchk("lock cleared", `CSP_OFF_STATUS, 32'h0);
        apb(1'b1, `CSP_OFF_PLL0, 32'h0);
        repeat (3) @(posedge pclk);
        chk("pll0 off", 32'h7, 32'(pll_pd));
        $display("test pll done");

        apb(1'b1, `CSP_OFF_PERCLK, 32'h0000fffe);
        repeat (10) @(posedge pclk);
        toggles(3'h2, 200, t);
        chk("gated periph", 32'h0, 32'(t));
        toggles(3'h3, 200, t);
        chk("open periph", 32'h1, 32'(t > 0));
        $display("test gating done");

        apb(1'b1, `CSP_OFF_SLEEP, 32'h1);
        rchk("asleep", `CSP_OFF_SLEEP, 32'h1);
        repeat (10) @(posedge pclk);
        toggles(3'h1, 200, t);
        chk("core stopped", 32'h0, 32'(t));
        toggles(3'h3, 200, t);
        chk("periph in sleep", 32'h1, 32'(t > 0));
        irq_pending <= 1'b1;
        @(posedge pclk);
        irq_pending <= 1'b0;
        rchk("awake", `CSP_OFF_SLEEP, 32'h0);
        toggles(3'h1, 200, t);
        chk("core running", 32'h1, 32'(t > 0));
        $display("test sleep done");

        toggles(3'h6, 2000, t);
        chk("khz ticks", 32'h1, 32'(t >= 3 && t <= 6));
        toggles(3'h7, 200, t);
        chk("hz tick quiet", 32'h0, 32'(t));
        $display("test rtc done");
        final_report();
    end
endmodule
`default_nettype wire
